/* File: rtl/dtdcb_regs.svh */
// Register offsets, field positions, reset values and timing of the threshold bank.
`ifndef DTDCB_REGS_SVH
`define DTDCB_REGS_SVH

// Register indices; the byte address is four times the index.
`define DTDCB_IDX_THR_HIGH   6'h07
`define DTDCB_IDX_THR_LOW    6'h08

// Reset values.
`define DTDCB_RST_THR_HIGH   16'h0000
`define DTDCB_RST_THR_LOW    16'h0000

// Field positions inside the threshold-low register.
`define DTDCB_TLO_TH_MSB     15
`define DTDCB_TLO_TH_LSB     8
`define DTDCB_TLO_RSV_MSB    7
`define DTDCB_TLO_RSV_LSB    4
`define DTDCB_TLO_SEL_MSB    3
`define DTDCB_TLO_SEL_LSB    0

// Selector code that turns the offset-removal filter off.
`define DTDCB_SEL_OFF        4'h0

// Cycles from a taken request to waitrequest low.
`define DTDCB_ACK_CYCLES     1

`endif

/* File: rtl/dtdcb_pkg.sv */
// Types shared by the threshold and offset-removal register bank.
package dtdcb_pkg;

    // Which register an access addresses.
    typedef enum logic [1:0] {
        DTDCB_SEL_NONE,
        DTDCB_SEL_HIGH,
        DTDCB_SEL_LOW
    } dtdcb_sel_t;

    // Configuration word handed to the coefficient decoder.
    typedef logic [3:0] dtdcb_coeff_sel_t;

    // Right shift that realises the filter coefficient.
    typedef logic [4:0] dtdcb_shift_t;

endpackage : dtdcb_pkg

/* File: rtl/dtdcb_cfg_if.sv */
// Interface carrying the filter selector to the coefficient decoder and its result back.
`timescale 1ns/1ps
interface dtdcb_cfg_if;
    dtdcb_pkg::dtdcb_coeff_sel_t sel;      // Stored selector code.
    logic                        enable;   // Filter enabled, registered.
    dtdcb_pkg::dtdcb_shift_t     shift;    // Coefficient as a power of two, registered.

    modport bank (output sel, input enable, input shift);
    modport dec  (input sel, output enable, output shift);
endinterface : dtdcb_cfg_if

/* File: rtl/dtdcb_coeff.sv */
// Decoder that turns the offset-removal selector into an enable and a coefficient shift.
`timescale 1ns/1ps
`include "dtdcb_regs.svh"
module dtdcb_coeff (
    input  wire logic clk,      // System clock, 20 MHz.
    input  wire logic rst_n,    // Asynchronous reset, active low.
    dtdcb_cfg_if.dec  cfg       // Selector in, decoded result out.
);

    logic                    enable_d;
    logic                    enable_q;
    dtdcb_pkg::dtdcb_shift_t shift_d;
    dtdcb_pkg::dtdcb_shift_t shift_q;

    // Code zero switches the filter off; code n gives a coefficient of 2 to the -(n+1).
    always_comb
    begin
        enable_d = (cfg.sel != `DTDCB_SEL_OFF);                         // [R6]
        shift_d  = enable_d ? 5'({1'b0, cfg.sel} + 5'h01) : 5'h00;      // [R7]
    end

    // The result is registered so the datapath sees a clean value.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_q <= 1'b0;
            shift_q  <= 5'h00;
        end
        else
        begin
            enable_q <= enable_d;
            shift_q  <= shift_d;
        end
    end

    assign cfg.enable = enable_q;
    assign cfg.shift  = shift_q;

    // A selector of one must mean a quarter, fifteen must mean 1/65536.
    AST_COEFF_QUARTER: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.sel == 4'h1 |=> shift_q == 5'h02)                             // [R7]
        else $error("Selector one did not give a shift of two.");
    AST_COEFF_LAST: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.sel == 4'hF |=> shift_q == 5'h10)                             // [R7]
        else $error("Selector fifteen did not give a shift of sixteen.");
    AST_COEFF_OFF: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.sel == `DTDCB_SEL_OFF |=> !enable_q && shift_q == 5'h00)     // [R6]
        else $error("Selector zero left the filter enabled.");

endmodule : dtdcb_coeff

/* File: rtl/dtdcb_top.sv */
// Current-detect threshold and offset-removal register bank behind an Avalon-MM slave.
//
// Functional notes
// [R1] Threshold-high register holds 16 read-write upper threshold bits, reset zero.
// [R2] Threshold-high register sits at index 7h and resets to 0000h.
// [R3] Threshold-low register sits at index 8h and resets to 0000h.
// [R4] Threshold-low bits 15:8 hold the lower eight threshold bits, read-write.
// [R5] Threshold-low bits 7:4 read zero; software writes zeros there.
// [R6] Threshold-low bits 3:0 select the filter; zero disables it.
// [R7] Nonzero selector n sets coefficient 1/2^(n+1), from 1/4 to 1/65536.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "dtdcb_regs.svh"
module dtdcb_top (
    input  wire logic        clk,                       // System clock, 20 MHz.
    input  wire logic        rst_n,                     // Asynchronous reset, active low.
    input  wire logic [7:0]  avs_address,               // Byte address.
    input  wire logic        avs_read,                  // Read request.
    input  wire logic        avs_write,                 // Write request.
    input  wire logic [31:0] avs_writedata,             // Write data.
    input  wire logic [3:0]  avs_byteenable,            // Byte lanes of a write.
    output logic      [31:0] avs_readdata,              // Read data.
    output logic             avs_waitrequest,           // Low for the answering cycle.
    output logic      [23:0] detect_threshold,          // Full 24-bit threshold.
    output logic      [3:0]  offset_removal_coeff_sel,  // Stored selector code.
    output logic             offset_removal_en,         // Filter enabled.
    output logic      [4:0]  offset_removal_shift       // Coefficient as right shift.
);

    // ************************************************************
    // Address decode
    // ************************************************************

    // Maps a byte address onto one of the two registers, or onto none if unmapped or misaligned; used by reads and writes.
    function automatic dtdcb_pkg::dtdcb_sel_t dtdcb_decode(input logic [7:0] addr);
        dtdcb_pkg::dtdcb_sel_t sel;
        sel = dtdcb_pkg::DTDCB_SEL_NONE;
        if (addr[1:0] == 2'h0)
        begin
            if (addr[7:2] == `DTDCB_IDX_THR_HIGH)
            begin
                sel = dtdcb_pkg::DTDCB_SEL_HIGH;                       // [R2]
            end
            else if (addr[7:2] == `DTDCB_IDX_THR_LOW)
            begin
                sel = dtdcb_pkg::DTDCB_SEL_LOW;                        // [R3]
            end
        end
        return sel;
    endfunction : dtdcb_decode

    // Merges the low two byte lanes of a write into a stored 16-bit value.
    function automatic logic [15:0] dtdcb_merge(input logic [15:0] old_v,
                                                input logic [15:0] new_v,
                                                input logic [1:0]  be);
        logic [15:0] res;
        res[7:0]  = be[0] ? new_v[7:0]  : old_v[7:0];
        res[15:8] = be[1] ? new_v[15:8] : old_v[15:8];
        return res;
    endfunction : dtdcb_merge

    dtdcb_pkg::dtdcb_sel_t rd_sel;
    dtdcb_pkg::dtdcb_sel_t wr_sel;
    logic                  wr_commit;

    // The write takes effect only at the edge where the master sees waitrequest low.
    always_comb
    begin
        rd_sel    = dtdcb_decode(avs_address);
        wr_sel    = dtdcb_decode(avs_address);
        wr_commit = avs_write && !avs_waitrequest;
    end

    // ************************************************************
    // Bus handshake
    // ************************************************************

    // A literal cannot be part-selected, so the low reset word gets a name.
    localparam logic [15:0] RST_THR_LOW = `DTDCB_RST_THR_LOW;

    logic [15:0] thr_high_d;
    logic [15:0] thr_high_q;
    logic [7:0]  thr_low_d;
    logic [7:0]  thr_low_q;
    logic [3:0]  coeff_sel_d;
    logic [3:0]  coeff_sel_q;
    logic [15:0] thr_low_rd;
    logic [15:0] thr_low_new;
    logic        wait_d;
    logic        wait_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    // One wait cycle per access: waitrequest drops the cycle after a request appears
    // and rises again right after the answering edge, so back-to-back requests work.
    always_comb
    begin
        wait_d  = !((avs_read || avs_write) && wait_q);
        rdata_d = rdata_q;
        if (avs_read && wait_q)
        begin
            unique case (rd_sel)
                dtdcb_pkg::DTDCB_SEL_HIGH: rdata_d = {16'h0000, thr_high_q};
                dtdcb_pkg::DTDCB_SEL_LOW:  rdata_d = {16'h0000, thr_low_rd};
                dtdcb_pkg::DTDCB_SEL_NONE: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Handshake state; waitrequest rests high out of reset.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;

    // ************************************************************
    // Register storage
    // ************************************************************

    // Reserved bits are not stored at all, so whatever software writes there
    // cannot leak back on a read.
    always_comb
    begin
        thr_low_rd  = {thr_low_q, 4'h0, coeff_sel_q};                  // [R5]
        thr_low_new = dtdcb_merge(thr_low_rd, avs_writedata[15:0], avs_byteenable[1:0]);
        thr_high_d  = thr_high_q;
        thr_low_d   = thr_low_q;
        coeff_sel_d = coeff_sel_q;
        if (wr_commit && wr_sel == dtdcb_pkg::DTDCB_SEL_HIGH)
        begin
            thr_high_d = dtdcb_merge(thr_high_q, avs_writedata[15:0],
                                     avs_byteenable[1:0]);             // [R1]
        end
        if (wr_commit && wr_sel == dtdcb_pkg::DTDCB_SEL_LOW)
        begin
            thr_low_d   = thr_low_new[`DTDCB_TLO_TH_MSB:`DTDCB_TLO_TH_LSB];     // [R4]
            coeff_sel_d = thr_low_new[`DTDCB_TLO_SEL_MSB:`DTDCB_TLO_SEL_LSB];   // [R6]
        end
    end

    // Register contents; both registers clear to zero.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            thr_high_q  <= `DTDCB_RST_THR_HIGH;                               // [R2]
            thr_low_q   <= RST_THR_LOW[`DTDCB_TLO_TH_MSB:`DTDCB_TLO_TH_LSB];  // [R3]
            coeff_sel_q <= RST_THR_LOW[`DTDCB_TLO_SEL_MSB:`DTDCB_TLO_SEL_LSB];
        end
        else
        begin
            thr_high_q  <= thr_high_d;
            thr_low_q   <= thr_low_d;
            coeff_sel_q <= coeff_sel_d;
        end
    end

    // ************************************************************
    // Outputs to the detect engine and the filter
    // ************************************************************

    dtdcb_cfg_if cfg_bus ();

    assign cfg_bus.sel = coeff_sel_q;

    dtdcb_coeff u_coeff (
        .clk   (clk),
        .rst_n (rst_n),
        .cfg   (cfg_bus.dec)
    );

    // The high word is the upper part of the 24-bit threshold.
    assign detect_threshold         = {thr_high_q, thr_low_q};                // [R1]
    assign offset_removal_coeff_sel = coeff_sel_q;
    assign offset_removal_en        = cfg_bus.enable;                         // [R6]
    assign offset_removal_shift     = cfg_bus.shift;                          // [R7]

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking dtdcb_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_HIGH_WRITE: assert property (                                         // [R1]
        wr_commit && wr_sel == dtdcb_pkg::DTDCB_SEL_HIGH && avs_byteenable[1:0] == 2'h3
        |=> thr_high_q == $past(avs_writedata[15:0]))
        else $error("Threshold-high write was not stored.");
    AST_HIGH_READ: assert property (                                          // [R2]
        avs_read && wait_q && avs_address == {`DTDCB_IDX_THR_HIGH, 2'h0}
        |=> !avs_waitrequest && avs_readdata == {16'h0000, $past(thr_high_q)})
        else $error("Read of index 7h did not return the high word.");
    AST_LOW_READ: assert property (                                           // [R3]
        avs_read && wait_q && avs_address == {`DTDCB_IDX_THR_LOW, 2'h0}
        |=> !avs_waitrequest && avs_readdata == {16'h0000, $past(thr_low_rd)})
        else $error("Read of index 8h did not return the low register.");
    AST_LOW_THRESH: assert property (                                         // [R4]
        wr_commit && wr_sel == dtdcb_pkg::DTDCB_SEL_LOW && avs_byteenable[1]
        |=> detect_threshold[7:0] == $past(avs_writedata[15:8]))
        else $error("Low threshold byte did not follow the write.");
    AST_RSV_ZERO: assert property (                                           // [R5]
        !avs_waitrequest && avs_read && avs_address == {`DTDCB_IDX_THR_LOW, 2'h0}
        |-> avs_readdata[7:4] == 4'h0)
        else $error("Reserved bits read as nonzero.");
    AST_SEL_DECODE: assert property (                                         // [R6]
        wr_commit && wr_sel == dtdcb_pkg::DTDCB_SEL_LOW && avs_byteenable[0]
        ##1 1'b1 |=> offset_removal_en == ($past(avs_writedata[3:0], 2) != 4'h0))
        else $error("Filter enable did not follow the written selector.");
    AST_SHIFT: assert property (                                              // [R7]
        offset_removal_en |-> offset_removal_shift == 5'({1'b0, $past(coeff_sel_q)} + 5'h01))
        else $error("Coefficient shift does not match selector plus one.");
    AST_ONE_WAIT: assert property (
        (avs_read || avs_write) && wait_q |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Waitrequest was not low for exactly one cycle.");

    COV_HIGH_WRITE: cover property (wr_commit && wr_sel == dtdcb_pkg::DTDCB_SEL_HIGH);
    COV_LOW_READ:   cover property (!avs_waitrequest && avs_read
                                    && rd_sel == dtdcb_pkg::DTDCB_SEL_LOW);
    COV_FILTER_ON:  cover property (!offset_removal_en ##1 offset_removal_en);
    COV_UNMAPPED:   cover property (!avs_waitrequest && rd_sel == dtdcb_pkg::DTDCB_SEL_NONE);

endmodule : dtdcb_top

/* File: testbench/dtdcb_top_tb.sv */
// Self-checking testbench for the threshold and offset-removal register bank.
`timescale 1ns/1ps
`include "dtdcb_regs.svh"
module dtdcb_top_tb;

    // ************************************************************
    // Signals, clock and reset
    // ************************************************************
    logic        clk;
    logic        rst_n;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [23:0] detect_threshold;
    logic [3:0]  offset_removal_coeff_sel;
    logic        offset_removal_en;
    logic [4:0]  offset_removal_shift;
    int          num_errors;
    int          comparisons;
    logic [31:0] rd;
    logic [3:0]  code;
    localparam logic [7:0] ADDR_HI = {`DTDCB_IDX_THR_HIGH, 2'b00};
    localparam logic [7:0] ADDR_LO = {`DTDCB_IDX_THR_LOW, 2'b00};

    dtdcb_top dtdcb_top_i (
        .clk                      (clk),
        .rst_n                    (rst_n),
        .avs_address              (avs_address),
        .avs_read                 (avs_read),
        .avs_write                (avs_write),
        .avs_writedata            (avs_writedata),
        .avs_byteenable           (avs_byteenable),
        .avs_readdata             (avs_readdata),
        .avs_waitrequest          (avs_waitrequest),
        .detect_threshold         (detect_threshold),
        .offset_removal_coeff_sel (offset_removal_coeff_sel),
        .offset_removal_en        (offset_removal_en),
        .offset_removal_shift     (offset_removal_shift)
    );

    // The clock runs at 20 MHz.
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ************************************************************
    // Bus and comparison tasks
    // ************************************************************
    // Compare one value and count the outcome.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One Avalon access; the request is held until waitrequest is sampled low.
    task automatic bus_access(input logic wr, input logic [7:0] addr,
                              input logic [31:0] data, input logic [3:0] be,
                              output logic [31:0] rdata);
        int waited;
        waited = 0;
        @(posedge clk);
        avs_address    <= addr;
        avs_writedata  <= data;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= ~wr;
        do
        begin
            @(posedge clk);
            waited++;
        end
        while (avs_waitrequest !== 1'b0 && waited < 20);
        rdata = avs_readdata;
        check(32'(waited), 32'(1 + `DTDCB_ACK_CYCLES), "answer latency");
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus_access

    task automatic bus_write(input logic [7:0] addr, input logic [31:0] data,
                             input logic [3:0] be);
        logic [31:0] unused;
        bus_access(1'b1, addr, data, be, unused);
    endtask : bus_write

    task automatic bus_read(input logic [7:0] addr, input logic [31:0] exp, input string what);
        logic [31:0] got;
        bus_access(1'b0, addr, 32'h0000_0000, 4'h0, got);
        check(got, exp, what);
    endtask : bus_read

    // Let the decoded outputs settle, since enable and shift lag by one clock.
    task automatic check_outputs(input logic [15:0] hi, input logic [15:0] lo);
        repeat (2) @(posedge clk);
        #1;
        check(32'(detect_threshold), 32'({hi, lo[15:8]}), "threshold output");
        check(32'(offset_removal_coeff_sel), 32'(lo[3:0]), "selector output");
        check(32'(offset_removal_en), 32'(lo[3:0] != 4'h0), "filter enable");
        check(32'(offset_removal_shift), (lo[3:0] == 4'h0) ? 32'h0 : 32'(lo[3:0]) + 32'h1,
              "coefficient shift");
    endtask : check_outputs

    // Print the counts and the verdict, then stop.
    task automatic results;
        $display("errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // ************************************************************
    // Test sequence
    // ************************************************************
    // A wrong answer must not be able to hide behind a hang.
    initial
    begin
        #100000;
        num_errors++;
        $display("wrong value at %0t: watchdog expired", $time);
        results();
    end

    initial
    begin
        num_errors = 0;
        comparisons = 0;
        rst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        check_outputs(16'h0000, 16'h0000);
        bus_read(ADDR_HI, 32'h0000_0000, "high reset");
        bus_read(ADDR_LO, 32'h0000_0000, "low reset");
        // Full writes; the upper word must be dropped, reserved bits are written as zeros.
        bus_write(ADDR_HI, 32'hFFFF_A5C3, 4'hF);
        bus_read(ADDR_HI, 32'h0000_A5C3, "high readback");
        bus_write(ADDR_LO, 32'h1234_9607, 4'hF);
        bus_read(ADDR_LO, 32'h0000_9607, "low readback");
        check_outputs(16'hA5C3, 16'h9607);
        // A single-lane write merges with the stored low byte.
        bus_write(ADDR_HI, 32'h0000_0000, 4'b0010);
        bus_read(ADDR_HI, 32'h0000_00C3, "lane merge");
        // Unmapped and misaligned places read zero and keep the bank unchanged.
        bus_write(8'h24, 32'h0000_FFFF, 4'hF);
        bus_write(8'h1D, 32'h0000_FFFF, 4'hF);
        bus_read(8'h24, 32'h0000_0000, "unmapped read");
        bus_read(8'h18, 32'h0000_0000, "unmapped read");
        bus_read(8'h1D, 32'h0000_0000, "misaligned read");
        bus_read(ADDR_HI, 32'h0000_00C3, "high untouched");
        bus_read(ADDR_LO, 32'h0000_9607, "low untouched");
        // Every selector code, with the reserved nibble written as zeros as software must.
        for (int n = 0; n < 16; n++)
        begin
            code = 4'(n);
            bus_write(ADDR_LO, {16'h0000, 8'h5A, 4'h0, code}, 4'b0011);
            check_outputs(16'h00C3, {8'h5A, 4'h0, code});
            bus_read(ADDR_LO, {16'h0000, 8'h5A, 4'h0, code}, "selector readback");
        end
        // A reset in mid-run clears both registers and the decoded outputs.
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        check_outputs(16'h0000, 16'h0000);
        bus_read(ADDR_HI, 32'h0000_0000, "high second reset");
        bus_read(ADDR_LO, 32'h0000_0000, "low second reset");
        results();
    end

endmodule : dtdcb_top_tb
